// ===== include/dsp_mac_consts.vh
// Constants for the pointer-update and multiply-accumulate datapath slice
`ifndef DSP_MAC_CONSTS_VH
`define DSP_MAC_CONSTS_VH

`define PTR_MOD_KEEP 3'h0
`define PTR_MOD_INC 3'h1
`define PTR_MOD_DEC 3'h2
`define PTR_MOD_STEP 3'h3
`define PTR_MOD_RING 3'h4
`define PTR_MOD_BREV 3'h5
`define PTR_MOD_IMM 3'h6

`define MAC_NONE 3'h0
`define MAC_MADD 3'h1
`define MAC_MSUB 3'h2
`define MAC_SU 3'h3
`define MAC_UU 3'h4
`define MAC_SH1 3'h5
`define MAC_SH16 3'h6
`define MAC_MUL 3'h7

`define LS_NONE 2'h0
`define LS_LOAD 2'h1
`define LS_STORE 2'h2

`define PART_WHOLE 3'h0
`define PART_LO 3'h1
`define PART_HI 3'h2
`define PART_EXT 3'h3
`define PART_EXT_HI 3'h4

`define IDX_PTR_BASE 6'h00
`define IDX_STEP_BASE 6'h08
`define IDX_X_RING 6'h10
`define IDX_Y_RING 6'h11
`define IDX_STATUS 6'h12
`define IDX_ACC_LO_BASE 6'h20
`define IDX_ACC_EXT_BASE 6'h28

`define OVF_BIT 0
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define RST_WORD16 16'h0000
`define RST_ACC 40'h0000000000

`endif

// ===== design/ptr_update.v
// Post-access pointer arithmetic and access address generation
`timescale 1ns/1ps
`default_nettype none
`include "dsp_mac_consts.vh"
module ptr_update (
  input wire [15:0] ptr_in,
  input wire [15:0] step_in,
  input wire [15:0] ring_in,
  input wire [15:0] imm_in,
  input wire [2:0] mod_in,
  output reg [15:0] next_ptr_out,
  output wire [15:0] access_addr_out
);
  wire [15:0] ring_mask;
  wire [15:0] rev_ptr;
  wire [15:0] ptr_low_part;
  wire [15:0] ptr_high_part;
  wire [16:0] ring_p1;
  wire [16:0] ring_sum;
  reg [16:0] ring_wrap;

  genvar i;
  generate
    for (i = 0; i < 16; i = i + 1)
    begin : g_bit
      assign ring_mask[i] = |ring_in[15:i];
      assign rev_ptr[i] = ptr_in[15 - i];
    end
  endgenerate

  assign ptr_low_part = ptr_in & ring_mask;
  assign ptr_high_part = ptr_in & ~ring_mask;
  assign ring_p1 = {1'b0, ring_in} + 17'h00001;
  assign ring_sum = {1'b0, ptr_low_part} + {step_in[15], step_in};
  // Access always uses the stored value; only the bit-reversed form alters it
  assign access_addr_out = (mod_in == `PTR_MOD_BREV) ? rev_ptr : ptr_in;

  // Steps are assumed no larger than one ring length, so one correction wraps
  always @*
  begin
    if (ring_sum[16])
      ring_wrap = ring_sum + ring_p1;
    else if (ring_sum >= ring_p1)
      ring_wrap = ring_sum - ring_p1;
    else
      ring_wrap = ring_sum;
  end

  always @*
  begin
    case (mod_in)
      `PTR_MOD_KEEP: next_ptr_out = ptr_in;
      `PTR_MOD_INC: next_ptr_out = ptr_in + 16'h0001;
      `PTR_MOD_DEC: next_ptr_out = ptr_in - 16'h0001;
      `PTR_MOD_STEP: next_ptr_out = ptr_in + step_in;
      `PTR_MOD_RING: next_ptr_out = ring_wrap[15:0] + ptr_high_part;
      `PTR_MOD_BREV: next_ptr_out = ptr_in + step_in;
      `PTR_MOD_IMM: next_ptr_out = ptr_in + imm_in;
      default: next_ptr_out = ptr_in;
    endcase
  end
endmodule
`default_nettype wire

// ===== design/dsp_mac_ptr.v
// Pointer update and multiply-accumulate datapath with AXI4-Lite register access
`timescale 1ns/1ps
`default_nettype none
`include "dsp_mac_consts.vh"
module dsp_mac_ptr (
  input wire core_clk_in,
  input wire arst_n_in,
  input wire [7:0] s_axi_awaddr_in,
  input wire s_axi_awvalid_in,
  output reg s_axi_awready_out,
  input wire [31:0] s_axi_wdata_in,
  input wire [3:0] s_axi_wstrb_in,
  input wire s_axi_wvalid_in,
  output reg s_axi_wready_out,
  output reg [1:0] s_axi_bresp_out,
  output reg s_axi_bvalid_out,
  input wire s_axi_bready_in,
  input wire [7:0] s_axi_araddr_in,
  input wire s_axi_arvalid_in,
  output reg s_axi_arready_out,
  output reg [31:0] s_axi_rdata_out,
  output reg [1:0] s_axi_rresp_out,
  output reg s_axi_rvalid_out,
  input wire s_axi_rready_in,
  input wire instr_valid_in,
  input wire [2:0] mac_op_in,
  input wire [2:0] mac_dst_in,
  input wire [2:0] mac_src_a_in,
  input wire [2:0] mac_src_b_in,
  input wire [2:0] ptr_sel_in,
  input wire [2:0] ptr_mod_in,
  input wire [15:0] ptr_imm_in,
  input wire [1:0] ls_op_in,
  input wire [2:0] ls_reg_in,
  input wire [2:0] ls_part_in,
  input wire [15:0] mem_rdata_in,
  output reg [15:0] mem_addr_out,
  output reg mem_rd_out,
  output reg mem_wr_out,
  output reg [15:0] mem_wdata_out,
  output reg ovf_flag_out
);
  reg [15:0] addr_ptr [0:7];
  reg [15:0] ptr_step [0:7];
  reg [39:0] acc_reg [0:7];
  reg [15:0] x_ring_size;
  reg [15:0] y_ring_size;
  reg ld_pend;
  reg [2:0] ld_reg;
  reg [2:0] ld_part;
  reg aw_hold;
  reg w_hold;
  reg [7:0] aw_addr_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;
  reg [31:0] rd_data;
  reg rd_err;
  reg wr_err;
  reg signed [41:0] prod;
  reg signed [41:0] base;
  reg signed [41:0] mac_sum;
  reg mac_ovf_en;
  reg [39:0] ld_value;
  reg [15:0] st_value;
  wire [15:0] upd_ptr;
  wire [15:0] access_addr;
  wire [15:0] cur_ring;
  wire [39:0] acc_dst;
  wire [39:0] acc_a;
  wire [39:0] acc_b;
  wire [39:0] ld_old;
  wire [39:0] st_src;
  wire [5:0] wr_idx;
  wire [5:0] rd_idx;
  wire do_wr;
  wire mac_ovf;
  integer k;

  assign cur_ring = ptr_sel_in[2] ? y_ring_size : x_ring_size;
  assign acc_dst = acc_reg[mac_dst_in];
  assign acc_a = acc_reg[mac_src_a_in];
  assign acc_b = acc_reg[mac_src_b_in];
  assign ld_old = acc_reg[ld_reg];
  assign st_src = acc_reg[ls_reg_in];
  assign wr_idx = aw_addr_q[7:2];
  assign rd_idx = s_axi_araddr_in[7:2];
  assign do_wr = aw_hold & w_hold & ~s_axi_bvalid_out;

  ptr_update u_ptr_update (
    .ptr_in(addr_ptr[ptr_sel_in]),
    .step_in(ptr_step[ptr_sel_in]),
    .ring_in(cur_ring),
    .imm_in(ptr_imm_in),
    .mod_in(ptr_mod_in),
    .next_ptr_out(upd_ptr),
    .access_addr_out(access_addr)
  );

  // Partial byte strobes merge into the 16-bit registers
  function [15:0] merge16;
    input [15:0] old;
    input [31:0] data;
    input [3:0] strb;
    begin
      merge16 = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
    end
  endfunction

  always @*
  begin
    prod = 42'sh0;
    base = {{2{acc_dst[39]}}, acc_dst};
    mac_ovf_en = 1'b1;
    case (mac_op_in)
      `MAC_MADD: prod = $signed(acc_a[31:16]) * $signed(acc_b[31:16]);
      `MAC_MSUB: prod = $signed(acc_a[31:16]) * $signed(acc_b[31:16]);
      `MAC_SU: prod = $signed(acc_a[31:16]) * $signed({1'b0, acc_b[15:0]});
      `MAC_UU: prod = $signed({1'b0, acc_a[15:0]}) * $signed({1'b0, acc_b[15:0]});
      `MAC_SH1:
      begin
        prod = $signed(acc_a[31:16]) * $signed(acc_b[31:16]);
        base = {{3{acc_dst[39]}}, acc_dst[39:1]};
      end
      `MAC_SH16:
      begin
        prod = $signed(acc_a[31:16]) * $signed(acc_b[31:16]);
        base = {{18{acc_dst[39]}}, acc_dst[39:16]};
        mac_ovf_en = 1'b0;
      end
      `MAC_MUL:
      begin
        prod = $signed(acc_a[31:16]) * $signed(acc_b[31:16]);
        base = 42'sh0;
        mac_ovf_en = 1'b0;
      end
      default: mac_ovf_en = 1'b0;
    endcase
    if (mac_op_in == `MAC_MSUB)
      mac_sum = base - prod;
    else
      mac_sum = base + prod;
  end

  // Overflow means the 42-bit sum no longer fits the 40-bit accumulator
  assign mac_ovf = instr_valid_in & mac_ovf_en &
                   (mac_sum[41:39] != 3'h0) & (mac_sum[41:39] != 3'h7);

  always @*
  begin
    case (ld_part)
      `PART_LO: ld_value = {ld_old[39:16], mem_rdata_in};
      `PART_HI: ld_value = {ld_old[39:32], mem_rdata_in, ld_old[15:0]};
      `PART_EXT: ld_value = {mem_rdata_in[7:0], ld_old[31:0]};
      `PART_EXT_HI: ld_value = {{8{mem_rdata_in[15]}}, mem_rdata_in, ld_old[15:0]};
      default: ld_value = {{24{mem_rdata_in[15]}}, mem_rdata_in};
    endcase
    case (ls_part_in)
      `PART_HI: st_value = st_src[31:16];
      `PART_EXT: st_value = {{8{st_src[39]}}, st_src[39:32]};
      `PART_EXT_HI: st_value = st_src[31:16];
      default: st_value = st_src[15:0];
    endcase
  end

  always @*
  begin
    rd_data = 32'h00000000;
    rd_err = 1'b0;
    if (rd_idx < `IDX_STEP_BASE)
      rd_data = {16'h0000, addr_ptr[rd_idx[2:0]]};
    else if (rd_idx < `IDX_X_RING)
      rd_data = {16'h0000, ptr_step[rd_idx[2:0]]};
    else if (rd_idx == `IDX_X_RING)
      rd_data = {16'h0000, x_ring_size};
    else if (rd_idx == `IDX_Y_RING)
      rd_data = {16'h0000, y_ring_size};
    else if (rd_idx == `IDX_STATUS)
      rd_data = {31'h00000000, ovf_flag_out};
    else if (rd_idx >= `IDX_ACC_LO_BASE && rd_idx < `IDX_ACC_EXT_BASE)
      rd_data = acc_reg[rd_idx[2:0]][31:0];
    else if (rd_idx >= `IDX_ACC_EXT_BASE && rd_idx < 6'h30)
      rd_data = {24'h000000, acc_reg[rd_idx[2:0]][39:32]};
    else
      rd_err = 1'b1;
    wr_err = ~(wr_idx <= `IDX_STATUS);
  end

  // AXI4-Lite handshakes: address and data latched in either order
  always @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      s_axi_awready_out <= 1'b1;
      s_axi_wready_out <= 1'b1;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= `RESP_OKAY;
      s_axi_arready_out <= 1'b1;
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= 32'h00000000;
      s_axi_rresp_out <= `RESP_OKAY;
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid_in && s_axi_awready_out)
      begin
        aw_hold <= 1'b1;
        aw_addr_q <= s_axi_awaddr_in;
        s_axi_awready_out <= 1'b0;
      end
      if (s_axi_wvalid_in && s_axi_wready_out)
      begin
        w_hold <= 1'b1;
        w_data_q <= s_axi_wdata_in;
        w_strb_q <= s_axi_wstrb_in;
        s_axi_wready_out <= 1'b0;
      end
      if (do_wr)
      begin
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out <= wr_err ? `RESP_SLVERR : `RESP_OKAY;
      end
      if (s_axi_bvalid_out && s_axi_bready_in)
      begin
        s_axi_bvalid_out <= 1'b0;
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        s_axi_awready_out <= 1'b1;
        s_axi_wready_out <= 1'b1;
      end
      if (s_axi_arvalid_in && s_axi_arready_out)
      begin
        s_axi_arready_out <= 1'b0;
        s_axi_rvalid_out <= 1'b1;
        s_axi_rdata_out <= rd_data;
        s_axi_rresp_out <= rd_err ? `RESP_SLVERR : `RESP_OKAY;
      end
      if (s_axi_rvalid_out && s_axi_rready_in)
      begin
        s_axi_rvalid_out <= 1'b0;
        s_axi_arready_out <= 1'b1;
      end
    end
  end

  // Datapath state; later assignments win, so instruction updates override software
  always @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      for (k = 0; k < 8; k = k + 1)
      begin
        addr_ptr[k] <= `RST_WORD16;
        ptr_step[k] <= `RST_WORD16;
        acc_reg[k] <= `RST_ACC;
      end
      x_ring_size <= `RST_WORD16;
      y_ring_size <= `RST_WORD16;
      ovf_flag_out <= 1'b0;
      ld_pend <= 1'b0;
      ld_reg <= 3'h0;
      ld_part <= 3'h0;
      mem_addr_out <= `RST_WORD16;
      mem_rd_out <= 1'b0;
      mem_wr_out <= 1'b0;
      mem_wdata_out <= `RST_WORD16;
    end
    else
    begin
      if (do_wr && !wr_err)
      begin
        if (wr_idx < `IDX_STEP_BASE)
          addr_ptr[wr_idx[2:0]] <= merge16(addr_ptr[wr_idx[2:0]], w_data_q, w_strb_q);
        else if (wr_idx < `IDX_X_RING)
          ptr_step[wr_idx[2:0]] <= merge16(ptr_step[wr_idx[2:0]], w_data_q, w_strb_q);
        else if (wr_idx == `IDX_X_RING)
          x_ring_size <= merge16(x_ring_size, w_data_q, w_strb_q);
        else if (wr_idx == `IDX_Y_RING)
          y_ring_size <= merge16(y_ring_size, w_data_q, w_strb_q);
        else if (w_strb_q[0] && w_data_q[`OVF_BIT])
          ovf_flag_out <= 1'b0;
      end
      if (mac_ovf)
        ovf_flag_out <= 1'b1;
      // Load data is captured at the end of the cycle that carries the read strobe
      if (ld_pend)
        acc_reg[ld_reg] <= ld_value;
      ld_pend <= instr_valid_in && ls_op_in == `LS_LOAD;
      mem_rd_out <= instr_valid_in && ls_op_in == `LS_LOAD;
      mem_wr_out <= instr_valid_in && ls_op_in == `LS_STORE;
      if (instr_valid_in)
      begin
        if (mac_op_in != `MAC_NONE)
          acc_reg[mac_dst_in] <= mac_sum[39:0];
        if (ls_op_in != `LS_NONE)
        begin
          mem_addr_out <= access_addr;
          mem_wdata_out <= st_value;
          ld_reg <= ls_reg_in;
          ld_part <= ls_part_in;
        end
        addr_ptr[ptr_sel_in] <= upd_ptr;
      end
    end
  end
endmodule
`default_nettype wire

// ===== bench/dsp_mac_ptr_monitor.sv
// Assertion checker for the pointer-update and multiply-accumulate datapath
`timescale 1ns/1ps
`default_nettype none
`include "dsp_mac_consts.vh"
module dsp_mac_ptr_monitor (
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  input wire logic s_axi_bvalid_out,
  input wire logic s_axi_arvalid_in,
  input wire logic s_axi_arready_out,
  input wire logic s_axi_rvalid_out,
  input wire logic instr_valid_in,
  input wire logic [2:0] mac_op_in,
  input wire logic [1:0] ls_op_in,
  input wire logic mem_rd_out,
  input wire logic mem_wr_out,
  input wire logic [15:0] mem_addr_out,
  input wire logic ovf_flag_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!arst_n_in);
  load_pulse_a: assert property (
    instr_valid_in && ls_op_in == `LS_LOAD |=> mem_rd_out && !mem_wr_out)
    else $error("Load issued without a read pulse");
  read_cause_a: assert property (
    mem_rd_out |-> $past(instr_valid_in && ls_op_in == `LS_LOAD))
    else $error("Read pulse without a load");
  store_pulse_a: assert property (
    instr_valid_in && ls_op_in == `LS_STORE |=> mem_wr_out && !mem_rd_out)
    else $error("Store issued without a write pulse");
  write_cause_a: assert property (
    mem_wr_out |-> $past(instr_valid_in && ls_op_in == `LS_STORE))
    else $error("Write pulse without a store");
  ovf_rise_a: assert property (
    $rose(ovf_flag_out) |-> $past(instr_valid_in && mac_op_in >= `MAC_MADD
      && mac_op_in <= `MAC_SH1))
    else $error("Overflow flag set by an operation that may not set it");
  ovf_sticky_a: assert property (
    $fell(ovf_flag_out) |-> $rose(s_axi_bvalid_out))
    else $error("Overflow flag cleared without a register write");
  read_answer_a: assert property (
    s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out && !s_axi_arready_out)
    else $error("Read address taken without a read answer");
  addr_hold_a: assert property (
    !mem_rd_out && !mem_wr_out |-> $stable(mem_addr_out))
    else $error("Memory address moved without an access");
endmodule
bind dsp_mac_ptr dsp_mac_ptr_monitor i_monitor (.core_clk_in(core_clk_in),
  .arst_n_in(arst_n_in), .s_axi_bvalid_out(s_axi_bvalid_out),
  .s_axi_arvalid_in(s_axi_arvalid_in), .s_axi_arready_out(s_axi_arready_out),
  .s_axi_rvalid_out(s_axi_rvalid_out), .instr_valid_in(instr_valid_in),
  .mac_op_in(mac_op_in), .ls_op_in(ls_op_in), .mem_rd_out(mem_rd_out),
  .mem_wr_out(mem_wr_out), .mem_addr_out(mem_addr_out), .ovf_flag_out(ovf_flag_out));
`default_nettype wire

// ===== bench/mem_model.sv
// Behavioural data memory on the far side of the load/store port
`timescale 1ns/1ps
`default_nettype none
module mem_model (
  input wire logic core_clk_in,
  input wire logic [15:0] addr_in,
  input wire logic rd_in,
  input wire logic wr_in,
  input wire logic [15:0] wdata_in,
  output logic [15:0] rdata_out
);
  logic [15:0] mem [0:255];
  logic [15:0] last = 16'h0000;
  // Outside a read the bus shows the inverse of the last word, so stale data never matches
  assign rdata_out = rd_in ? mem[addr_in[7:0]] : ~last;
  always @(posedge core_clk_in)
  begin
    if (rd_in)
      last <= mem[addr_in[7:0]];
    if (wr_in)
      mem[addr_in[7:0]] <= wdata_in;
  end
endmodule
`default_nettype wire

// ===== bench/test_dsp_mac_ptr.sv
// Testbench for the pointer-update and multiply-accumulate datapath
`timescale 1ns/1ps
`default_nettype none
`include "dsp_mac_consts.vh"
module test_dsp_mac_ptr;
  logic core_clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0, iv = 1'b0;
  logic [31:0] wd = 32'h00000000;
  logic [31:0] rdata;
  logic [1:0] bresp, rresp;
  logic [1:0] ls = 2'h0;
  logic awr, wrdy, bv, arr, rv, mrd, mwr, ovf;
  logic [2:0] op = 3'h0, dst = 3'h0, sa = 3'h0, sb = 3'h0, sel = 3'h0, md = 3'h0;
  logic [2:0] lr = 3'h0, lp = 3'h0;
  logic [15:0] imm = 16'h0000;
  logic [15:0] mrdata, maddr, mwd;
  // MAC table entries are {op, src a, src b}
  logic [8:0] mt [7] = '{9'h04A, 9'h08A, 9'h1CA, 9'h14A, 9'h18A, 9'h0D1, 9'h109};
  logic [39:0] mx [7] = '{40'hFFFFFFFFFA, 40'h0000000000, 40'hFFFFFFFFFA, 40'hFFFFFFFFF7,
    40'hFFFFFFFFF9, 40'hFFFFFEFFF9, 40'h003FFEFFF9};
  logic [15:0] exp_q [$];
  int n_errors = 0;
  int compares = 0;
  int i;
  dsp_mac_ptr i_dut (
    .core_clk_in(core_clk_in), .arst_n_in(arst_n_in),
    .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv), .s_axi_awready_out(awr),
    .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'h3), .s_axi_wvalid_in(wv), .s_axi_wready_out(wrdy),
    .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bv), .s_axi_bready_in(br),
    .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rv), .s_axi_rready_in(rr),
    .instr_valid_in(iv), .mac_op_in(op), .mac_dst_in(dst), .mac_src_a_in(sa), .mac_src_b_in(sb),
    .ptr_sel_in(sel), .ptr_mod_in(md), .ptr_imm_in(imm), .ls_op_in(ls), .ls_reg_in(lr),
    .ls_part_in(lp), .mem_rdata_in(mrdata), .mem_addr_out(maddr), .mem_rd_out(mrd),
    .mem_wr_out(mwr), .mem_wdata_out(mwd), .ovf_flag_out(ovf));
  mem_model i_mem (.core_clk_in(core_clk_in), .addr_in(maddr), .rd_in(mrd), .wr_in(mwr),
    .wdata_in(mwd), .rdata_out(mrdata));
  initial
  begin
    forever #12.5 core_clk_in = ~core_clk_in;
  end
  task automatic chk(input logic [39:0] g, input logic [39:0] e);
    compares++;
    if (g !== e)
    begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge core_clk_in);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    do
    begin
      @(posedge core_clk_in);
      if (awr)
        awv <= 1'b0;
      if (wrdy)
        wv <= 1'b0;
    end while (bv !== 1'b1);
    br <= 1'b0;
    chk({38'h0, bresp}, {38'h0, er});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge core_clk_in);
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    do
    begin
      @(posedge core_clk_in);
      if (arr)
        arv <= 1'b0;
    end while (rv !== 1'b1);
    rr <= 1'b0;
    chk({8'h00, rdata}, {8'h00, ed});
    chk({38'h0, rresp}, {38'h0, er});
  endtask
  task automatic issue(input logic [2:0] o, d, a, b, s, m, input logic [15:0] im,
    input logic [1:0] l, input logic [2:0] r, p);
    @(posedge core_clk_in);
    iv <= 1'b1;
    op <= o;
    dst <= d;
    sa <= a;
    sb <= b;
    sel <= s;
    md <= m;
    imm <= im;
    ls <= l;
    lr <= r;
    lp <= p;
  endtask
  // Two edges after the last instruction cover the one-cycle load return
  task automatic idle;
    @(posedge core_clk_in);
    iv <= 1'b0;
    repeat (2) @(posedge core_clk_in);
  endtask
  task automatic pt(input logic [2:0] s, m, input logic [15:0] p, st, im, ea, ep);
    wr({3'b000, s, 2'b00}, {16'h0000, p}, `RESP_OKAY);
    wr({3'b001, s, 2'b00}, {16'h0000, st}, `RESP_OKAY);
    exp_q.push_back(ea);
    issue(`MAC_NONE, 3'h7, 3'h0, 3'h0, s, m, im, `LS_LOAD, 3'h7, `PART_LO);
    idle;
    rd({3'b000, s, 2'b00}, {16'h0000, ep}, `RESP_OKAY);
  endtask
  task automatic acc(input logic [2:0] n, input logic [39:0] e);
    rd({3'b100, n, 2'b00}, e[31:0], `RESP_OKAY);
    rd({3'b101, n, 2'b00}, {24'h000000, e[39:32]}, `RESP_OKAY);
  endtask
  task automatic results;
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Every load or store pulse must carry the next queued address
  always @(negedge core_clk_in)
  begin
    if (mrd === 1'b1 || mwr === 1'b1)
      chk({24'h0, maddr}, {24'h0, exp_q.pop_front()});
  end
  initial
  begin
    #125000;
    n_errors++;
    results;
  end
  initial
  begin
    repeat (10) @(posedge core_clk_in);
    arst_n_in <= 1'b1;
    rd(8'h48, 32'h0, `RESP_OKAY);
    rd(8'h4C, 32'h0, `RESP_SLVERR);
    wr(8'h80, 32'h1234, `RESP_SLVERR);
    rd(8'h80, 32'h0, `RESP_OKAY);
    wr(8'h40, 32'h7, `RESP_OKAY);
    wr(8'h44, 32'hF, `RESP_OKAY);
    $display("register access test done");
    pt(3'h0, `PTR_MOD_KEEP, 16'h0010, 16'h0, 16'h0, 16'h0010, 16'h0010);
    pt(3'h0, `PTR_MOD_INC, 16'h0010, 16'h0, 16'h0, 16'h0010, 16'h0011);
    pt(3'h0, `PTR_MOD_DEC, 16'h0010, 16'h0, 16'h0, 16'h0010, 16'h000F);
    pt(3'h1, `PTR_MOD_RING, 16'h0046, 16'h3, 16'h0, 16'h0046, 16'h0041);
    pt(3'h4, `PTR_MOD_RING, 16'h203E, 16'h5, 16'h0, 16'h203E, 16'h2033);
    pt(3'h2, `PTR_MOD_BREV, 16'h0001, 16'h2, 16'h0, 16'h8000, 16'h0003);
    for (i = 0; i < 8; i++)
    begin
      pt(i[2:0], `PTR_MOD_STEP, {5'h0, i[2:0], 8'h20}, {13'h0, i[2:0]} + 16'h1, 16'h0,
        {5'h0, i[2:0], 8'h20}, {5'h0, i[2:0], 8'h21} + {13'h0, i[2:0]});
      pt(i[2:0], `PTR_MOD_IMM, {5'h0, i[2:0], 8'h20}, 16'h0, 16'h0F00,
        {5'h0, i[2:0], 8'h20}, {5'h0, i[2:0], 8'h20} + 16'h0F00);
    end
    $display("pointer test done");
    i_mem.mem[1] = 16'h0003;
    i_mem.mem[2] = 16'hFFFE;
    i_mem.mem[3] = 16'h8000;
    i_mem.mem[4] = 16'h9ABC;
    i_mem.mem[5] = 16'hFFFF;
    i_mem.mem[6] = 16'h12A5;
    i_mem.mem[7] = 16'h8001;
    wr(8'h00, 32'h1, `RESP_OKAY);
    for (i = 1; i < 8; i++)
      exp_q.push_back(i[15:0]);
    issue(`MAC_NONE, 3'h0, 3'h0, 3'h0, 3'h0, `PTR_MOD_INC, 16'h0, `LS_LOAD, 3'h1, `PART_HI);
    issue(`MAC_NONE, 3'h0, 3'h0, 3'h0, 3'h0, `PTR_MOD_INC, 16'h0, `LS_LOAD, 3'h2, `PART_HI);
    issue(`MAC_NONE, 3'h0, 3'h0, 3'h0, 3'h0, `PTR_MOD_INC, 16'h0, `LS_LOAD, 3'h1, `PART_LO);
    issue(`MAC_NONE, 3'h0, 3'h0, 3'h0, 3'h0, `PTR_MOD_INC, 16'h0, `LS_LOAD, 3'h6, `PART_WHOLE);
    issue(`MAC_NONE, 3'h0, 3'h0, 3'h0, 3'h0, `PTR_MOD_INC, 16'h0, `LS_LOAD, 3'h4, `PART_LO);
    issue(`MAC_NONE, 3'h0, 3'h0, 3'h0, 3'h0, `PTR_MOD_INC, 16'h0, `LS_LOAD, 3'h2, `PART_EXT);
    issue(`MAC_NONE, 3'h0, 3'h0, 3'h0, 3'h0, `PTR_MOD_INC, 16'h0, `LS_LOAD, 3'h4, `PART_EXT_HI);
    idle;
    rd(8'h00, 32'h8, `RESP_OKAY);
    acc(3'h6, 40'hFFFFFF9ABC);
    acc(3'h1, 40'h0000038000);
    acc(3'h2, 40'hA5FFFE0000);
    acc(3'h4, 40'hFF8001FFFF);
    for (i = 0; i < 7; i++)
    begin
      issue(mt[i][8:6], 3'h3, mt[i][5:3], mt[i][2:0], 3'h0, `PTR_MOD_KEEP, 16'h0, `LS_NONE,
        3'h0, 3'h0);
      idle;
      acc(3'h3, mx[i]);
      chk({39'h0, ovf}, 40'h0);
    end
    $display("multiply test done");
    for (i = 0; i < 128; i++)
      issue(`MAC_UU, 3'h5, 3'h4, 3'h4, 3'h0, `PTR_MOD_KEEP, 16'h0, `LS_NONE, 3'h0, 3'h0);
    idle;
    chk({39'h0, ovf}, 40'h0);
    issue(`MAC_UU, 3'h5, 3'h4, 3'h4, 3'h0, `PTR_MOD_KEEP, 16'h0, `LS_NONE, 3'h0, 3'h0);
    idle;
    chk({39'h0, ovf}, 40'h1);
    exp_q.push_back(16'h0008);
    issue(`MAC_MUL, 3'h3, 3'h1, 3'h2, 3'h0, `PTR_MOD_INC, 16'h0, `LS_STORE, 3'h1, `PART_LO);
    idle;
    chk({24'h0, mwd}, 40'h8000);
    chk({39'h0, ovf}, 40'h1);
    acc(3'h3, 40'hFFFFFFFFFA);
    wr(8'h48, 32'h1, `RESP_OKAY);
    rd(8'h48, 32'h0, `RESP_OKAY);
    chk({39'h0, ovf}, 40'h0);
    $display("overflow test done");
    results;
  end
endmodule
`default_nettype wire
